// file: design/lpsr_top.sv
// Purpose: Latched parallel-in serial-out shift register with three-state output
// Assumes: Pins are asynchronous to mclk; edges are seen after synchronising
// Notes: Pin samples pass an 8-word FIFO before latch and shift register act on them; oe_n bypasses it
// Operation
// - Latch captures parallel pins on latch edge
// - Shift mode edge loads serial, moves stages
// - Load mode ignores the serial input
// - Shift mode changes register only on edges
// - Load mode copies latch into register continuously
// - Last stage leaves, replaced by previous stage
// - Enable high floats output, low drives it
// - Enable never touches latch or register
// - Output shows final register stage
// - Load mode latch edge fills both stores
// - Shift mode simultaneous edges latch and shift together
// - No edges in shift mode, latch and register hold
`timescale 1ns/1ps
`include "lpsr_regs.svh"

module lpsr_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = `LPSR_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;
	assign in_ready = cnt_q != (AW + 1)'(DEPTH);
	assign out_valid = cnt_q != '0;
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (32'(wr_q) == DEPTH - 1) ? '0 : AW'(wr_q + 1'b1);
			end
			if (pop) begin
				rd_q <= (32'(rd_q) == DEPTH - 1) ? '0 : AW'(rd_q + 1'b1);
			end
			cnt_q <= (AW + 1)'(cnt_q + (AW + 1)'(push) - (AW + 1)'(pop));
		end
	end

	////////////////////////////////////////////////////////////////////////
	fifo_bound_a: assert property (@(posedge mclk) disable iff (rst)
		32'(cnt_q) <= DEPTH)
		else $error("fifo count past depth");

	fifo_push_a: assert property (@(posedge mclk) disable iff (rst)
		(push && !pop) |=> 32'(cnt_q) == 32'($past(cnt_q)) + 1)
		else $error("fifo push not counted");

	fifo_pop_a: assert property (@(posedge mclk) disable iff (rst)
		(pop && !push) |=> 32'(cnt_q) == 32'($past(cnt_q)) - 1)
		else $error("fifo pop not counted");

	fifo_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(push == pop) |=> $stable(cnt_q))
		else $error("fifo count drifted");

	fifo_first_a: assert property (@(posedge mclk) disable iff (rst)
		(push && !out_valid) |=> out_data == $past(in_data))
		else $error("fifo head not first word");
endmodule

////////////////////////////////////////////////////////////////////////////////

module lpsr_top
	import lpsr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire lpsr_pkg::lpsr_pins_t pins,
	output logic ser_out,
	output logic ser_out_oe,
	output logic [`LPSR_WIDTH-1:0] latch_stage_content,
	output logic [`LPSR_WIDTH-1:0] shift_stage_content,
	output logic loaded,
	output logic overrun
);
	localparam int PW = $bits(lpsr_pins_t);
	lpsr_pins_t s1_q;
	lpsr_pins_t s2_q;
	lpsr_pins_t s3_q;
	lpsr_pins_t stable_q;
	logic changed;
	logic ff_ready;
	logic ff_valid;
	lpsr_pins_t ff_data;
	lpsr_pins_t prev_q;
	logic [`LPSR_WIDTH-1:0] latch_q;
	logic [`LPSR_WIDTH-1:0] shreg_q;
	logic lat_edge;
	logic sh_edge;

	////////////////////////////////////////////////////////////////////////
	// Three-stage synchroniser, accept a change once stages two and three agree
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stable_q <= '1;
		end else begin
			s1_q <= pins;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				stable_q <= s3_q;
			end
		end
	end
	assign changed = (s2_q == s3_q) && (s3_q != stable_q);

	sync_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(s2_q != s3_q) |=> $stable(stable_q))
		else $error("pin change taken before settling");

	lpsr_fifo #(.WIDTH(PW), .DEPTH(`LPSR_FIFO_DEPTH)) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(changed),
		.in_ready(ff_ready),
		.in_data(s3_q),
		.out_valid(ff_valid),
		.out_ready(1'b1),
		.out_data(ff_data)
	);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			overrun <= 1'b0;
		end else if (changed && !ff_ready) begin
			overrun <= 1'b1;
		end
	end

	sync_push_a: assert property (@(posedge mclk) disable iff (rst)
		changed |-> ff_ready)
		else $error("pin change dropped");

	////////////////////////////////////////////////////////////////////////
	// Edge detect on dequeued pin snapshots
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prev_q <= '1;
		end else if (ff_valid) begin
			prev_q <= ff_data;
		end
	end
	assign lat_edge = ff_valid && ff_data.latch_clk && !prev_q.latch_clk;
	assign sh_edge = ff_valid && ff_data.shift_clk && !prev_q.shift_clk;

	////////////////////////////////////////////////////////////////////////
	// Latch; oe_n plays no part here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_q <= `LPSR_ZERO8;
		end else if (lat_edge) begin
			latch_q <= ff_data.par;
		end
	end

	latch_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!lat_edge |=> $stable(latch_q))
		else $error("latch changed without edge");

	////////////////////////////////////////////////////////////////////////
	// Shift register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			shreg_q <= `LPSR_ZERO8;
		end else if (ff_valid && !ff_data.mode_shift) begin
			// Load mode: transparent from latch, serial pin unused
			shreg_q <= lat_edge ? ff_data.par : latch_q;
		end else if (sh_edge) begin
			shreg_q <= {shreg_q[`LPSR_LAST-1:0], ff_data.ser};
		end else if (!ff_valid && !prev_q.mode_shift) begin
			shreg_q <= latch_q;
		end
	end

	shift_out_a: assert property (@(posedge mclk) disable iff (rst)
		(sh_edge && ff_data.mode_shift) |=>
			shreg_q[`LPSR_LAST] == $past(shreg_q[`LPSR_LAST-1]))
		else $error("last stage not fed by previous");

	both_edge_a: assert property (@(posedge mclk) disable iff (rst)
		(lat_edge && sh_edge && ff_data.mode_shift) |=>
			latch_q == $past(ff_data.par) &&
			shreg_q == {$past(shreg_q[`LPSR_LAST-1:0]), $past(ff_data.ser)})
		else $error("simultaneous edges lost one");

	load_idle_a: assert property (@(posedge mclk) disable iff (rst)
		(!ff_valid && !prev_q.mode_shift) |=> shreg_q == $past(latch_q))
		else $error("load mode copy stalled");

	level_only_a: assert property (@(posedge mclk) disable iff (rst)
		(ff_valid && ff_data.mode_shift && !lat_edge && !sh_edge) |=>
			$stable(latch_q) && $stable(shreg_q))
		else $error("level change moved data");

	load_out_a: assert property (@(posedge mclk) disable iff (rst)
		(!ff_valid && !prev_q.mode_shift) |=> ##1
			ser_out == $past(latch_q[`LPSR_LAST], 2))
		else $error("output not latch last stage");

	edge_out_a: assert property (@(posedge mclk) disable iff (rst)
		(lat_edge && !ff_data.mode_shift) |=> ##1
			ser_out == $past(ff_data.par[`LPSR_LAST], 2))
		else $error("output not last parallel bit");

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			loaded <= 1'b0;
		end else if (ff_valid && !ff_data.mode_shift) begin
			loaded <= 1'b1;
		end
	end

	loaded_set_a: assert property (@(posedge mclk) disable iff (rst)
		(ff_valid && !ff_data.mode_shift) |=> loaded)
		else $error("load not flagged");

	loaded_keep_a: assert property (@(posedge mclk) disable iff (rst)
		loaded |=> loaded)
		else $error("load flag dropped");

	////////////////////////////////////////////////////////////////////////
	// Output driver
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ser_out <= 1'b0;
			ser_out_oe <= 1'b0;
		end else begin
			ser_out <= shreg_q[`LPSR_LAST];
			ser_out_oe <= !stable_q.oe_n;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			latch_stage_content <= `LPSR_ZERO8;
			shift_stage_content <= `LPSR_ZERO8;
		end else begin
			latch_stage_content <= latch_q;
			shift_stage_content <= shreg_q;
		end
	end

	mirror_out_a: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> latch_stage_content == $past(latch_q) &&
			shift_stage_content == $past(shreg_q))
		else $error("store copies lag");

	////////////////////////////////////////////////////////////////////////
	latch_cap_a: assert property (@(posedge mclk) disable iff (rst)
		lat_edge |=> latch_q == $past(ff_data.par))
		else $error("latch missed capture");
	shift_move_a: assert property (@(posedge mclk) disable iff (rst)
		(sh_edge && ff_data.mode_shift) |=>
			shreg_q == {$past(shreg_q[`LPSR_LAST-1:0]), $past(ff_data.ser)})
		else $error("shift wrong");
	load_copy_a: assert property (@(posedge mclk) disable iff (rst)
		(ff_valid && !ff_data.mode_shift && !lat_edge) |=> shreg_q == $past(latch_q))
		else $error("load copy wrong");
	both_load_a: assert property (@(posedge mclk) disable iff (rst)
		(lat_edge && !ff_data.mode_shift) |=>
			shreg_q == $past(ff_data.par) && latch_q == $past(ff_data.par))
		else $error("load edge not in both");
	hold_still_a: assert property (@(posedge mclk) disable iff (rst)
		(!ff_valid && prev_q.mode_shift) |=> $stable(shreg_q) && $stable(latch_q))
		else $error("changed without edge");
	out_last_a: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> ser_out == $past(shreg_q[`LPSR_LAST]))
		else $error("output not last stage");
	out_en_a: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> ser_out_oe == !$past(stable_q.oe_n))
		else $error("enable wrong");
	shift_only_a: assert property (@(posedge mclk) disable iff (rst)
		(ff_valid && ff_data.mode_shift && !sh_edge) |=> $stable(shreg_q))
		else $error("shift without edge");
	ser_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		(sh_edge && !ff_data.mode_shift && !lat_edge) |=> shreg_q == $past(latch_q))
		else $error("serial leaked");
endmodule

// file: design/lpsr_regs.svh
// Purpose: Named constants for the latched parallel-in serial-out shifter
// Assumes: Included by its bare name
// Notes: Definitions only
`ifndef LPSR_REGS_SVH
`define LPSR_REGS_SVH
`define LPSR_WIDTH 8
`define LPSR_FIFO_DEPTH 8
`define LPSR_ZERO8 8'h00
`define LPSR_ZERO3 3'h0
`define LPSR_ZERO4 4'h0
`define LPSR_LAST 7
`endif

// file: design/lpsr_pkg.sv
// Purpose: Types shared by the shifter files
// Assumes: Constants come from lpsr_regs.svh
// Notes: Pin inputs travel as one struct
`include "lpsr_regs.svh"
package lpsr_pkg;
	typedef struct packed {
		logic [`LPSR_WIDTH-1:0] par;
		logic ser;
		logic mode_shift;
		logic latch_clk;
		logic shift_clk;
		logic oe_n;
	} lpsr_pins_t;
endpackage

// file: tb/lpsr_host.sv
// Purpose: Serial host that drives the shifter pins
// Assumes: One pin change per call
// Notes: Each level is held 9 mclk
`timescale 1ns/1ps
module lpsr_host
	import lpsr_pkg::*;
(
	input wire logic mclk,
	output lpsr_pkg::lpsr_pins_t pins
);
	initial pins = '0;
	////////////////////////////////////////////////////////////////
	// Wide spacing keeps every edge far above the 2 mclk minimum
	task put(input lpsr_pins_t p);
		@(posedge mclk);
		#1 pins = p;
		repeat (8) @(posedge mclk);
	endtask
endmodule

// file: tb/latched_piso_shift_register_test.sv
// Purpose: Self-checking bench for the latched shifter
// Assumes: Reset value 0 stands for unknown contents
// Notes: Checks follow the second pin change of each pulse, after settling
`timescale 1ns/1ps
module latched_piso_shift_register_test;
	import lpsr_pkg::*;
	logic mclk = 0;
	logic rst = 1;
	lpsr_pins_t pins;
	lpsr_pins_t p;
	logic ser_out, ser_out_oe, loaded, overrun;
	logic [7:0] lat_q, sh_q, m_lat, m_sh;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	always #2.5 mclk = ~mclk;
	lpsr_host lpsr_host_i(.mclk(mclk), .pins(pins));
	lpsr_top lpsr_top_i(.mclk(mclk), .rst(rst), .pins(pins), .ser_out(ser_out),
		.ser_out_oe(ser_out_oe), .latch_stage_content(lat_q),
		.shift_stage_content(sh_q), .loaded(loaded), .overrun(overrun));
	////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Levels first, then clock edges, then model update and compare
	task pulse(input logic md, input logic lc, input logic sc, input logic sd,
		input logic [7:0] pv);
		p = pins;
		p.mode_shift = md;
		p.ser = sd;
		p.par = pv;
		p.oe_n = 1'($urandom);
		p.latch_clk = 1'b0;
		p.shift_clk = 1'b0;
		lpsr_host_i.put(p);
		p.latch_clk = lc;
		p.shift_clk = sc;
		lpsr_host_i.put(p);
		if (lc) m_lat = pv;
		if (md && sc) m_sh = {m_sh[6:0], sd};
		if (!md) m_sh = m_lat;
		chk(lat_q, m_lat);
		chk(sh_q, m_sh);
		chk({7'h00, ser_out}, {7'h00, m_sh[7]});
		chk({7'h00, ser_out_oe}, {7'h00, ~p.oe_n});
		chk({7'h00, loaded}, 8'h01);
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done;
		end
	end
	initial begin
		void'($urandom(32'h699B));
		m_lat = 8'h00;
		m_sh = 8'h00;
		repeat (2) @(posedge mclk);
		#1 rst = 0;
		chk(sh_q, 8'h00);
		chk({7'h00, loaded}, 8'h00);
		for (int i = 0; i < 12; i++) begin
			pulse(1'b0, 1'b1, 1'b0, 1'b0, 8'($urandom));
			for (int j = 0; j < 8; j++) begin
				pulse(1'b1, j[0], 1'b1, 1'($urandom), 8'($urandom));
			end
			pulse(1'b1, 1'b0, 1'b0, 1'($urandom), 8'($urandom));
			pulse(1'b0, 1'b0, 1'b1, 1'($urandom), 8'($urandom));
		end
		chk({7'h00, overrun}, 8'h00);
		test_done;
	end
endmodule
